/* logic/apcrt_pkg.sv */
// shared constants and types for the converter pair-config and reference timing block
package apcrt_pkg;

  // ---------------------------------------------------------------
  // setup command byte layout
  // ---------------------------------------------------------------
  localparam int unsigned SETUP_ID_HI   = 7;     // command class field
  localparam int unsigned SETUP_ID_LO   = 6;
  localparam logic [1:0]  SETUP_ID      = 2'h1;  // class value of a setup command
  localparam int unsigned CLK_MODE_HI   = 5;     // conversion clock mode field
  localparam int unsigned CLK_MODE_LO   = 4;
  localparam int unsigned VREF_HI       = 3;     // vref_choice_hi
  localparam int unsigned VREF_LO       = 2;     // vref_choice_lo
  localparam int unsigned SEL_HI        = 1;     // pair_cfg_sel_hi
  localparam int unsigned SEL_LO        = 0;     // pair_cfg_sel_lo
  localparam int unsigned BYTE_LAST_BIT = 7;     // bit index of the eighth serial bit

  // ---------------------------------------------------------------
  // field encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] CLK_MODE_EXT  = 2'h3;   // external conversion clock mode
  localparam logic [1:0] VREF_INT_ALL  = 2'h0;   // internal for both converters
  localparam logic [1:0] VREF_EXT_SE   = 2'h1;   // external single-ended
  localparam logic [1:0] VREF_DEFAULT  = 2'h2;   // internal adc, external dac
  localparam logic [1:0] VREF_EXT_DIFF = 2'h3;   // external differential

  // ---------------------------------------------------------------
  // pair registers: only the four upper bits carry meaning
  // ---------------------------------------------------------------
  localparam int unsigned PAIR_HI = 7;           // pair 0/1 lives in bit 7
  localparam int unsigned PAIR_LO = 4;           // pair 6/7 lives in bit 4

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] PAIR_RST     = 4'h0;    // all single-ended unipolar
  localparam logic [1:0] CLK_MODE_RST = 2'h0;
  localparam logic [1:0] VREF_RST     = VREF_DEFAULT;

  // ---------------------------------------------------------------
  // delays, in external conversion clock cycles
  // ---------------------------------------------------------------
  localparam logic [7:0] REF_WARM_CYC = 8'hf4;   // 244 cycles of reference settling
  localparam logic [7:0] TEMP_OUT_CYC = 8'hbc;   // 188 cycles until the result shows
  localparam logic [7:0] AIN_WAKE_CYC = 8'hda;   // 218 cycles when the reference was off

  // reference sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WARM = 4'h2,
    ST_TOUT = 4'h4,
    ST_AWAK = 4'h8
  } apcrt_ref_state_t;

endpackage : apcrt_pkg

/* logic/apcrt_sync.sv */
// two-flop synchroniser for pins from outside the system clock domain
`timescale 1ns/1ps
module apcrt_sync #(
  parameter int          WIDTH   = 1,
  parameter logic [31:0] RST_VAL = 32'h0
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;   // first stage, read only by the second
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;   // second stage
  logic [WIDTH-1:0] sync_d;

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_q <= RST_VAL[WIDTH-1:0];
      sync_q <= RST_VAL[WIDTH-1:0];
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;

endmodule : apcrt_sync

/* logic/apcrt_core.sv */
// serial setup decoding, pair registers and reference delay sequencing
//
// Contract
// - external reference selected: internal reference unused except for temperature
// - ext-clock temperature: reference on, wait 244
// - temperature result on output after 188 more
// - select 10 default, reference off after scan
// - ext-clock default mode, reference off: wait 218 first
// - select 00/01: no data byte expected
// - select 00/01: pair registers unchanged
// - select 10: next byte loads unipolar register
// - select 11: next byte loads bipolar register
// - unipolar bit 7 makes pair 0/1
// - bits 6,5,4 make pairs 2/3,4/5,6/7
// - select field is command bits 1:0
// - no register selected: next byte is command
// - both pair registers reset to zero
`timescale 1ns/1ps
module apcrt_core
  import apcrt_pkg::*;
#(
  parameter int TEMP_W = 12                      // width of the temperature result
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // serial port pins
  input  wire logic              sclk,
  input  wire logic              csN,
  input  wire logic              din,
  output logic                   dout,
  output logic                   doutEn,
  // external conversion clock pin
  input  wire logic              extConvClk,
  // converter core requests
  input  wire logic              convReq,
  input  wire logic              convIsTemp,
  input  wire logic              scanDone,
  input  wire logic [TEMP_W-1:0] tempResult,
  // converter core controls
  output logic                   intRefOn,
  output logic                   adcUseIntRef,
  output logic                   convGo,
  output logic                   tempReady,
  output logic                   refBusy,
  // configuration state
  output logic [3:0]             uniPairs,
  output logic [3:0]             bipPairs,
  output logic [1:0]             vrefChoice,
  output logic [1:0]             clkMode
);

  // ---------------------------------------------------------------
  // pin synchronisation and edge finding
  // ---------------------------------------------------------------
  logic [3:0] pinSync;                           // {sclk, csN, din, extConvClk}
  logic       sclkS, csNS, dinS, extS;
  logic       sclkPrev_q, sclkPrev_d;            // last synced serial clock
  logic       extPrev_q, extPrev_d;              // last synced conversion clock
  logic       sclkRise, sclkFall, extRise;

  // chip select resets high so the port starts deselected
  apcrt_sync #(.WIDTH(4), .RST_VAL(32'h4)) uSync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .asyncIn ({sclk, csN, din, extConvClk}),
    .syncOut (pinSync)
  );

  // edges are found on the second stage only, never on the first
  always_comb begin
    {sclkS, csNS, dinS, extS} = pinSync;
    sclkPrev_d = sclkS;
    extPrev_d  = extS;
    sclkRise   = sclkS & ~sclkPrev_q;
    sclkFall   = ~sclkS & sclkPrev_q;
    extRise    = extS & ~extPrev_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclkPrev_q <= 1'b0;
      extPrev_q  <= 1'b0;
    end else begin
      sclkPrev_q <= sclkPrev_d;
      extPrev_q  <= extPrev_d;
    end
  end

  // ---------------------------------------------------------------
  // serial receive: command decode and pair registers
  // ---------------------------------------------------------------
  logic [6:0] shift_q, shift_d;                  // bits of the byte so far
  logic [2:0] bitCnt_q, bitCnt_d;                // position inside the byte
  logic       expData_q, expData_d;              // a data byte is owed
  logic       tgtBip_q, tgtBip_d;                // owed byte goes to bipolar
  logic [3:0] uni_q, uni_d;                      // unipolar pair bits 7..4
  logic [3:0] bip_q, bip_d;                      // bipolar pair bits 7..4
  logic [1:0] vref_q, vref_d;                    // reference choice
  logic [1:0] clkMode_q, clkMode_d;              // conversion clock mode
  logic [7:0] rxByte;                            // byte completed this cycle

  // bytes are taken msb first on rising serial clock edges
  always_comb begin
    shift_d   = shift_q;
    bitCnt_d  = bitCnt_q;
    expData_d = expData_q;
    tgtBip_d  = tgtBip_q;
    uni_d     = uni_q;
    bip_d     = bip_q;
    vref_d    = vref_q;
    clkMode_d = clkMode_q;
    rxByte    = {shift_q, dinS};
    if (csNS) begin
      // a deselect drops any half byte and any owed data byte
      bitCnt_d  = 3'h0;
      expData_d = 1'b0;
    end else if (sclkRise) begin
      shift_d  = rxByte[6:0];
      bitCnt_d = bitCnt_q + 3'h1;
      if (bitCnt_q == BYTE_LAST_BIT[2:0]) begin
        if (expData_q) begin
          // only bits 7..4 are kept; the low nibble has no effect
          if (tgtBip_q) begin
            bip_d = rxByte[PAIR_HI:PAIR_LO];
          end else begin
            uni_d = rxByte[PAIR_HI:PAIR_LO];
          end
          expData_d = 1'b0;                      // following byte is a command
        end else if (rxByte[SETUP_ID_HI:SETUP_ID_LO] == SETUP_ID) begin
          clkMode_d = rxByte[CLK_MODE_HI:CLK_MODE_LO];
          vref_d    = rxByte[VREF_HI:VREF_LO];
          // select 1x owes a data byte, 0x owes none and leaves pairs alone
          expData_d = rxByte[SEL_HI];
          tgtBip_d  = rxByte[SEL_LO];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      shift_q   <= 7'h00;
      bitCnt_q  <= 3'h0;
      expData_q <= 1'b0;
      tgtBip_q  <= 1'b0;
      uni_q     <= PAIR_RST;
      bip_q     <= PAIR_RST;
      vref_q    <= VREF_RST;
      clkMode_q <= CLK_MODE_RST;
    end else begin
      shift_q   <= shift_d;
      bitCnt_q  <= bitCnt_d;
      expData_q <= expData_d;
      tgtBip_q  <= tgtBip_d;
      uni_q     <= uni_d;
      bip_q     <= bip_d;
      vref_q    <= vref_d;
      clkMode_q <= clkMode_d;
    end
  end

  // ---------------------------------------------------------------
  // reference sequencer
  // ---------------------------------------------------------------
  apcrt_ref_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;                      // conversion clock edges seen
  logic       refOn_q, refOn_d;                  // internal reference powered
  logic       useInt_q, useInt_d;                // converter uses internal ref
  logic       convGo_q, convGo_d;                // start-conversion pulse
  logic       tempRdy_q, tempRdy_d;              // result loaded pulse
  logic       extMode;

  // true on the conversion clock edge that closes a delay of lim cycles
  function automatic logic delayDone(input logic [7:0] cnt, input logic [7:0] lim,
                                     input logic edgeNow);
    delayDone = edgeNow && (cnt == lim - 8'h01);
  endfunction : delayDone

  // delays are counted only in external clock mode; other modes start at once
  always_comb begin
    extMode   = (clkMode_q == CLK_MODE_EXT);
    state_d   = state_q;
    cnt_d     = cnt_q;
    refOn_d   = refOn_q;
    useInt_d  = useInt_q;
    convGo_d  = 1'b0;
    tempRdy_d = 1'b0;
    if (extRise) begin
      cnt_d = cnt_q + 8'h01;
    end
    case (state_q)
      ST_IDLE: begin
        cnt_d = 8'h00;
        if (convReq && convIsTemp) begin
          refOn_d  = 1'b1;                       // temperature always needs it
          useInt_d = 1'b1;
          if (extMode) begin
            state_d = ST_WARM;
          end else begin
            convGo_d = 1'b1;
          end
        end else if (convReq) begin
          if (vref_q == VREF_EXT_SE || vref_q == VREF_EXT_DIFF) begin
            useInt_d = 1'b0;                     // no power-up, no use
            convGo_d = 1'b1;
          end else begin
            refOn_d  = 1'b1;
            useInt_d = 1'b1;
            if (extMode && !refOn_q) begin
              state_d = ST_AWAK;                 // reference was off
            end else begin
              convGo_d = 1'b1;
            end
          end
        end else if (scanDone && (vref_q == VREF_DEFAULT || vref_q == VREF_INT_ALL)) begin
          refOn_d = 1'b0;                        // switched off after the scan
        end
      end
      ST_WARM: begin
        if (delayDone(cnt_q, REF_WARM_CYC, extRise)) begin
          convGo_d = 1'b1;                       // settled, convert now
          cnt_d    = 8'h00;
          state_d  = ST_TOUT;
        end
      end
      ST_TOUT: begin
        if (delayDone(cnt_q, TEMP_OUT_CYC, extRise)) begin
          tempRdy_d = 1'b1;                      // result goes to the output
          state_d   = ST_IDLE;
        end
      end
      ST_AWAK: begin
        if (delayDone(cnt_q, AIN_WAKE_CYC, extRise)) begin
          convGo_d = 1'b1;
          state_d  = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;                       // recover from an illegal code
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 8'h00;
      refOn_q   <= 1'b0;
      useInt_q  <= 1'b0;
      convGo_q  <= 1'b0;
      tempRdy_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      refOn_q   <= refOn_d;
      useInt_q  <= useInt_d;
      convGo_q  <= convGo_d;
      tempRdy_q <= tempRdy_d;
    end
  end

  // ---------------------------------------------------------------
  // serial transmit of the temperature result
  // ---------------------------------------------------------------
  logic [TEMP_W-1:0] tx_q, tx_d;                 // result shifted out msb first
  logic              avail_q, avail_d;           // a result waits to be read
  logic              read_q, read_d;             // frame has clocked result bits
  logic              dout_q, dout_d;
  logic              doutEn_q, doutEn_d;

  // bits change on falling serial clock edges so the host samples on rising;
  // a new result wins over the clear of the old one
  always_comb begin
    tx_d    = tx_q;
    avail_d = avail_q;
    read_d  = read_q;
    if (!csNS && avail_q && sclkFall) begin
      tx_d   = {tx_q[TEMP_W-2:0], 1'b0};
      read_d = 1'b1;
    end
    if (csNS && read_q) begin
      avail_d = 1'b0;                            // result consumed by that frame
      read_d  = 1'b0;
    end
    if (tempRdy_q) begin
      tx_d    = tempResult;
      avail_d = 1'b1;
      read_d  = 1'b0;
    end
    dout_d   = tx_d[TEMP_W-1];
    doutEn_d = ~csNS & avail_d;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_q     <= '0;
      avail_q  <= 1'b0;
      read_q   <= 1'b0;
      dout_q   <= 1'b0;
      doutEn_q <= 1'b0;
    end else begin
      tx_q     <= tx_d;
      avail_q  <= avail_d;
      read_q   <= read_d;
      dout_q   <= dout_d;
      doutEn_q <= doutEn_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign dout         = dout_q;
  assign doutEn       = doutEn_q;
  assign intRefOn     = refOn_q;
  assign adcUseIntRef = useInt_q;
  assign convGo       = convGo_q;
  assign tempReady    = tempRdy_q;
  assign refBusy      = ~state_q[0];
  assign uniPairs     = uni_q;
  assign bipPairs     = bip_q;
  assign vrefChoice   = vref_q;
  assign clkMode      = clkMode_q;

endmodule : apcrt_core

/* test/apcrt_core_assertions.sv */
// concurrent checks on the pair-config and reference timing block ports
`timescale 1ns/1ps
module apcrt_core_assertions (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // pins and requests
  input wire logic       csN,
  input wire logic       doutEn,
  input wire logic       convReq,
  input wire logic       convIsTemp,
  input wire logic       scanDone,
  // controls and state
  input wire logic       intRefOn,
  input wire logic       adcUseIntRef,
  input wire logic       convGo,
  input wire logic       tempReady,
  input wire logic       refBusy,
  input wire logic [3:0] uniPairs,
  input wire logic [3:0] bipPairs,
  input wire logic [1:0] vrefChoice,
  input wire logic [1:0] clkMode
);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // reset must be visible at release, so this one is never disabled
  a_reset_pairs: assert property (disable iff (1'b0) $rose(rst_n) |->
    uniPairs == 4'h0 && bipPairs == 4'h0) else $error("pairs not cleared");
  a_extref_direct: assert property (convReq && !refBusy && !convIsTemp && vrefChoice[0]
    |=> convGo && !adcUseIntRef) else $error("external ref conversion wrong");
  a_extref_refoff: assert property (convReq && !refBusy && !convIsTemp && vrefChoice[0]
    |=> $stable(intRefOn)) else $error("internal ref touched");
  a_warm_first: assert property (convReq && !refBusy && convIsTemp && clkMode == 2'h3
    |=> intRefOn && refBusy && !convGo) else $error("no reference warm-up");
  a_ready_pulse: assert property (tempReady |-> !refBusy ##1 !tempReady)
    else $error("result pulse wrong");
  a_warm_wait: assert property ($rose(refBusy) |-> !convGo [*8])
    else $error("conversion before delay");
  a_scan_off: assert property (scanDone && !refBusy && !vrefChoice[0] |=> !intRefOn)
    else $error("reference left on after scan");
  a_pairs_inframe: assert property ($changed(uniPairs) || $changed(bipPairs)
    |-> !$past(csN)) else $error("pairs changed outside a frame");
  a_dout_quiet: assert property (csN [*5] |-> !doutEn)
    else $error("output driven while deselected");

  // main scenarios
  c_conv: cover property (convGo);
  c_temp: cover property (tempReady);
  c_uni: cover property ($changed(uniPairs));
endmodule : apcrt_core_assertions

bind apcrt_core apcrt_core_assertions apcrt_core_assertions_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .csN(csN), .doutEn(doutEn), .convReq(convReq),
  .convIsTemp(convIsTemp), .scanDone(scanDone), .intRefOn(intRefOn),
  .adcUseIntRef(adcUseIntRef), .convGo(convGo), .tempReady(tempReady),
  .refBusy(refBusy), .uniPairs(uniPairs), .bipPairs(bipPairs),
  .vrefChoice(vrefChoice), .clkMode(clkMode));

/* test/apcrt_host.sv */
// host serial master model: mode 0 frames, 800 ns serial clock
`timescale 1ns/1ps
module apcrt_host (
  // system clock paces the serial clock
  input wire logic clk_sys,
  // serial pins
  input wire logic dout,
  output logic     sclk,
  output logic     csN,
  output logic     din
);
  // idle: clock parked low, deselected
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    din  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // one byte each way, msb first; data moves while the clock is low
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      din <= tx[i];
      tick(4);
      sclk <= 1'b1;
      tick(3);
      #1 rx[i] = dout;
      tick(1);
      sclk <= 1'b0;
    end
  endtask : xfer

  task automatic open_f;
    tick(1);
    csN <= 1'b0;
    tick(4);
  endtask : open_f

  // select held through all 16 clocks; released line shows no stale value
  task automatic close_f;
    tick(8);
    csN <= 1'b1;
    din <= ~din;
    tick(4);
  endtask : close_f
endmodule : apcrt_host

/* test/tb_top.sv */
// self-checking bench for the pair-config and reference timing block
`timescale 1ns/1ps
module tb_top;
  import apcrt_pkg::*;
  // ---------------------------------------------------------------
  // clocks, pins and bookkeeping
  // ---------------------------------------------------------------
  logic        clk_sys    = 1'b0;   // 10 MHz
  logic        rst_n      = 1'b0;
  logic        extConvClk = 1'b0;   // free-running conversion clock
  logic        convReq    = 1'b0;
  logic        convIsTemp = 1'b0;
  logic        scanDone   = 1'b0;
  logic [11:0] tempResult = 12'h000;
  logic        sclk, csN, din, dout, doutEn, intRefOn, adcUseIntRef;
  logic        convGo, tempReady, refBusy;
  logic [3:0]  uniPairs, bipPairs;
  logic [1:0]  vrefChoice, clkMode;
  logic [31:0] seed = 32'h6e00;
  int          bad_count = 0;
  int          total_checks = 0;
  int          ecnt = 0;            // conversion clock rises since a request

  always #50 clk_sys = ~clk_sys;
  always #500 extConvClk = ~extConvClk;
  always @(posedge extConvClk) ecnt++;

  apcrt_core #(.TEMP_W(12)) apcrt_core_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .csN(csN), .din(din),
    .dout(dout), .doutEn(doutEn), .extConvClk(extConvClk), .convReq(convReq),
    .convIsTemp(convIsTemp), .scanDone(scanDone), .tempResult(tempResult),
    .intRefOn(intRefOn), .adcUseIntRef(adcUseIntRef), .convGo(convGo),
    .tempReady(tempReady), .refBusy(refBusy), .uniPairs(uniPairs),
    .bipPairs(bipPairs), .vrefChoice(vrefChoice), .clkMode(clkMode));
  apcrt_host apcrt_host_inst (.clk_sys(clk_sys), .dout(dout), .sclk(sclk), .csN(csN),
    .din(din));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : nxt

  function automatic logic [7:0] setup(input logic [1:0] cm, rr, sel);
    return {SETUP_ID, cm, rr, sel};
  endfunction : setup

  task automatic chk_val(input logic [11:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input int got, exp, input string what);
    total_checks++;
    if (got != exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : chk_cnt

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // always a full 16-clock frame, even when no data byte is owed
  task automatic frame(input logic [7:0] a, b, output logic [15:0] rx);
    apcrt_host_inst.open_f();
    apcrt_host_inst.xfer(a, rx[15:8]);
    apcrt_host_inst.xfer(b, rx[7:0]);
    apcrt_host_inst.close_f();
  endtask : frame

  // bounded wait for the go pulse or the result pulse; entered just after an
  // edge, so the one-cycle pulse launched by that edge is looked at first
  task automatic wait_out(input bit temp, output int n);
    for (n = 1; n <= 3000; n++) begin
      #1;
      if ((temp ? tempReady : convGo) === 1'b1) return;
      @(posedge clk_sys);
    end
    bad_count++;
    $display("unexpected at %0t: no answer", $time);
    tally_and_finish();
  endtask : wait_out

  // issued mid-period so no conversion clock edge is in flight
  task automatic request(input logic temp, output int n);
    @(negedge extConvClk);
    @(posedge clk_sys);
    convReq    <= 1'b1;
    convIsTemp <= temp;
    @(posedge clk_sys);
    convReq <= 1'b0;
    ecnt = 0;
    wait_out(1'b0, n);
  endtask : request

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0]  d;
    logic [3:0]  eu, eb;
    logic [15:0] rx;
    logic [1:0]  sel;
    int          n;
    eu = 4'h0;
    eb = 4'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk_val(uniPairs, 12'h0, "uni reset");
    chk_val(bipPairs, 12'h0, "bip reset");
    chk_val(vrefChoice, 12'h2, "vref reset");
    for (int k = 0; k < 12; k++) begin
      seed = nxt(seed);
      d    = seed[7:0];
      sel  = k[1:0];
      if (k == 6) d = 8'h0f;           // only ignored bits set
      if (k == 7) d = 8'hf0;
      if (k == 10) d[5:4] = 2'h0;     // four-input style write
      if (!sel[1]) d[7:6] = 2'h2;      // stray byte, never a command
      if (sel == 2'h2) eu = d[7:4];
      if (sel == 2'h3) eb = d[7:4];
      frame(setup(2'h0, 2'h2, sel), d, rx);
      chk_val(uniPairs, eu, "uni pairs");
      chk_val(bipPairs, eb, "bip pairs");
    end
    frame(setup(2'h0, 2'h0, 2'h1), setup(2'h3, 2'h1, 2'h0), rx);
    chk_val(vrefChoice, 12'h1, "second command");
    chk_val(clkMode, 12'h3, "clock mode");
    chk_val(uniPairs, eu, "uni kept");
    request(1'b0, n);
    chk_cnt(n, 1, "external ref go");
    chk_val(adcUseIntRef, 12'h0, "adc ref use");
    chk_val(intRefOn, 12'h0, "internal ref off");
    seed = nxt(seed);
    @(posedge clk_sys);
    tempResult <= seed[11:0];
    request(1'b1, n);
    chk_cnt(ecnt, 244, "warm-up");
    chk_val(refBusy, 12'h1, "busy in result delay");
    ecnt = 0;
    wait_out(1'b1, n);
    chk_cnt(ecnt, 188, "result delay");
    chk_val(refBusy, 12'h0, "idle with result");
    frame(8'h00, 8'h00, rx);
    chk_val(rx[15:4], tempResult, "temperature out");
    frame(setup(2'h3, 2'h2, 2'h0), 8'h80, rx);
    @(posedge clk_sys);
    scanDone <= 1'b1;
    @(posedge clk_sys);
    scanDone <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk_val(intRefOn, 12'h0, "ref off after scan");
    request(1'b0, n);
    chk_cnt(ecnt, 218, "wake delay");
    chk_val(intRefOn, 12'h1, "ref woken");
    tally_and_finish();
  end
endmodule : tb_top
